// ---- cmd_decoder_params.svh ----
// constants for the fieldbus command word decoder
`ifndef CMD_DECODER_PARAMS_SVH
`define CMD_DECODER_PARAMS_SVH
`define CW_ON_BIT 4'h0
`define CW_COAST_N_BIT 4'h1
`define CW_QSTOP_N_BIT 4'h2
`define CW_START_BIT 4'h3
`define CW_RAMP_OUT_BIT 4'h4
`define CW_RAMP_HOLD_BIT 4'h5
`define CW_RAMP_IN_BIT 4'h6
`define CW_FAULT_ACK_BIT 4'h7
`define CW_JOG1_BIT 4'h8
`define CW_JOG2_BIT 4'h9
`define CW_FB_EN_BIT 4'hA
`define CW_WDOG_BIT 4'hB
`define CW_INTERNAL_BIT 4'hF
`define PLACE_FIELDBUS 3'h3
`define COMMAND_WORD_RESET 16'h0000
`define CLK_FREQ_HZ 250000000
`define WDOG_TICK_US 1000
`define WDOG_TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `WDOG_TICK_US)
`endif

// ---- cmd_decoder_pkg.sv ----
// types for the fieldbus command word decoder
package cmd_decoder_pkg;
  typedef enum logic [2:0] {
    SW_INHIBIT,
    SW_READY_ON,
    SW_READY_RUN,
    SW_RUNNING,
    SW_FAULT
  } drive_state_type;

  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_RAMP,
    STOP_COAST,
    STOP_QUICK
  } stop_kind_type;

  typedef enum logic [1:0] {
    RAMP_FOLLOW,
    RAMP_OUT_ZERO,
    RAMP_FREEZE,
    RAMP_IN_ZERO
  } ramp_mode_type;

  typedef struct packed {
    logic at_zero_speed;
    logic fault_active;
    logic fault_removed_voltage;
    logic aux_jog_enable;
    logic io_jog_enable;
    logic io_jog1;
    logic io_jog2;
    logic [1:0] quick_stop_mode;
  } drive_status_type;

  typedef struct packed {
    drive_state_type state;
    stop_kind_type stop_kind;
    ramp_mode_type ramp_mode;
    logic run_request;
    logic jog1_active;
    logic jog2_active;
    logic fault_ack;
    logic [1:0] quick_stop_mode;
    logic fieldbus_active;
  } drive_control_type;
endpackage

// ---- drive_fieldbus_command_decoder.sv ----
// decoder of the fieldbus command word into drive control state
`include "cmd_decoder_params.svh"
module drive_fieldbus_command_decoder #(
  parameter int WDOG_TICK = `WDOG_TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_write_i,
  input wire logic [15:0] fieldbus_command_word_i,
  input wire logic [2:0] control_place_select_i,
  input wire logic [15:0] watchdog_delay_setting_i,
  input wire cmd_decoder_pkg::drive_status_type status_i,
  output cmd_decoder_pkg::drive_control_type control_o,
  output logic [15:0] command_word_o,
  output logic watchdog_echo_o,
  output logic comm_fault_o,
  output logic bus_virtual_input_1_o,
  output logic bus_virtual_input_2_o,
  output logic bus_virtual_input_3_o,
  output logic bus_virtual_input_4_o
);
  import cmd_decoder_pkg::*;

  // ************************************
  // pin synchronisers for status inputs
  // ************************************
  drive_status_type stat_meta;
  drive_status_type stat;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_meta <= '0;
      stat <= '0;
    end else begin
      stat_meta <= status_i;
      stat <= stat_meta;
    end
  end

  // ************************************
  // command word capture
  // ************************************
  logic [15:0] command_word;
  logic [15:0] prev_word;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      command_word <= `COMMAND_WORD_RESET;
      prev_word <= `COMMAND_WORD_RESET;
    end else begin
      prev_word <= command_word;
      if (cmd_write_i) begin
        command_word <= fieldbus_command_word_i;
        command_word[`CW_INTERNAL_BIT] <= 1'b0;
      end
    end
  end

  function automatic logic rose(input logic [15:0] now, input logic [15:0] was,
                                input logic [3:0] idx);
    rose = now[idx] & ~was[idx];
  endfunction

  // ************************************
  // control decode
  // ************************************
  logic fb_enabled;
  logic jog_running;
  logic on_bit;
  logic coast_n;
  logic qstop_n;
  logic start_bit;
  logic on_rise;
  logic ack_rise;
  logic ramp_bits_zero;
  logic wd_fault;
  logic io_jog_req;
  logic io_jog_both;
  assign fb_enabled = command_word[`CW_FB_EN_BIT]
                      && control_place_select_i == `PLACE_FIELDBUS;
  assign on_bit = fb_enabled & command_word[`CW_ON_BIT];
  assign coast_n = ~fb_enabled | command_word[`CW_COAST_N_BIT];
  assign qstop_n = ~fb_enabled | command_word[`CW_QSTOP_N_BIT];
  assign start_bit = fb_enabled & command_word[`CW_START_BIT];
  assign on_rise = fb_enabled & rose(command_word, prev_word, `CW_ON_BIT);
  // edge lives one cycle only, prev_word catches up on the next edge
  assign ack_rise = fb_enabled & rose(command_word, prev_word, `CW_FAULT_ACK_BIT);
  assign ramp_bits_zero = ~command_word[`CW_RAMP_OUT_BIT] & ~command_word[`CW_RAMP_HOLD_BIT]
                          & ~command_word[`CW_RAMP_IN_BIT];
  assign io_jog_req = stat.io_jog_enable & (stat.io_jog1 | stat.io_jog2);
  assign io_jog_both = stat.io_jog1 & stat.io_jog2;

  // ************************************
  // drive state machine
  // ************************************
  drive_state_type state;
  drive_state_type next_state;
  stop_kind_type next_stop_kind;
  logic fault_any;
  assign fault_any = stat.fault_active | wd_fault;

  always_comb begin
    next_state = state;
    next_stop_kind = STOP_NONE;
    unique case (state)
      SW_INHIBIT: begin
        // master must toggle on bit before leaving inhibit
        if (on_rise && coast_n && qstop_n && !fault_any) begin
          next_state = SW_READY_RUN;
        end
      end
      SW_READY_ON: begin
        if (!coast_n) begin
          next_state = SW_INHIBIT;
        end else if (on_bit && qstop_n) begin
          next_state = SW_READY_RUN;
        end
      end
      SW_READY_RUN: begin
        if (!coast_n || !qstop_n) begin
          next_state = SW_INHIBIT;
        end else if (!on_bit) begin
          next_state = SW_READY_ON;
        end else if (start_bit || (io_jog_req && !io_jog_both)) begin
          next_state = SW_RUNNING;
        end
      end
      SW_RUNNING: begin
        // held for the whole stop, the stale word would otherwise ramp
        if (!fb_enabled) begin
          next_stop_kind = STOP_COAST;
          if (stat.at_zero_speed) next_state = SW_INHIBIT;
        end else if (!coast_n) begin
          next_stop_kind = STOP_COAST;
          if (stat.at_zero_speed) next_state = SW_INHIBIT;
        end else if (!qstop_n) begin
          next_stop_kind = STOP_QUICK;
          if (stat.at_zero_speed) next_state = SW_INHIBIT;
        end else if (!on_bit) begin
          next_stop_kind = STOP_RAMP;
          if (stat.at_zero_speed) next_state = SW_READY_ON;
        end else if (!start_bit && !(io_jog_req && !io_jog_both) && !jog_running) begin
          next_stop_kind = STOP_RAMP;
          if (stat.at_zero_speed) next_state = SW_READY_RUN;
        end
      end
      SW_FAULT: begin
        if (ack_rise) begin
          // voltage gone means a fresh on cycle is needed
          next_state = stat.fault_removed_voltage ? SW_INHIBIT : SW_READY_ON;
        end
      end
    endcase
    if (fault_any && state != SW_FAULT) begin
      next_state = SW_FAULT;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SW_INHIBIT;
    end else begin
      state <= next_state;
    end
  end

  // ************************************
  // jogging
  // ************************************
  logic fb_jog1;
  logic fb_jog2;
  logic ramp_locked;
  logic next_jog1;
  logic next_jog2;
  assign jog_running = fb_jog1 | fb_jog2;
  always_comb begin
    next_jog1 = 1'b0;
    next_jog2 = 1'b0;
    if (fb_enabled && stat.aux_jog_enable && ramp_bits_zero) begin
      // hold an accepted jog; accept a new one only at standstill
      if (jog_running || stat.at_zero_speed) begin
        next_jog1 = command_word[`CW_JOG1_BIT];
        next_jog2 = command_word[`CW_JOG2_BIT] & ~command_word[`CW_JOG1_BIT];
      end
    end
    if (stat.io_jog_enable && !start_bit && !io_jog_both) begin
      next_jog1 = next_jog1 | stat.io_jog1;
      next_jog2 = next_jog2 | stat.io_jog2;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fb_jog1 <= 1'b0;
      fb_jog2 <= 1'b0;
      ramp_locked <= 1'b0;
    end else begin
      fb_jog1 <= next_jog1;
      fb_jog2 <= next_jog2;
      // ramp bits wait for standstill after a jog ends
      if (jog_running && !(next_jog1 | next_jog2)) begin
        ramp_locked <= 1'b1;
      end else if (stat.at_zero_speed) begin
        ramp_locked <= 1'b0;
      end
    end
  end

  // ************************************
  // ramp mode, priority b4 > b5 > b6
  // ************************************
  ramp_mode_type ramp_mode;
  always_comb begin
    if (!fb_enabled || ramp_locked || jog_running) begin
      ramp_mode = RAMP_FOLLOW;
    end else if (!command_word[`CW_RAMP_OUT_BIT]) begin
      ramp_mode = RAMP_OUT_ZERO;
    end else if (!command_word[`CW_RAMP_HOLD_BIT]) begin
      ramp_mode = RAMP_FREEZE;
    end else if (!command_word[`CW_RAMP_IN_BIT]) begin
      ramp_mode = RAMP_IN_ZERO;
    end else begin
      ramp_mode = RAMP_FOLLOW;
    end
  end

  // ************************************
  // watchdog
  // ************************************
  wdog_monitor #(
    .TICK_CYCLES(WDOG_TICK)
  ) u_wdog (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .wdog_bit_i(command_word[`CW_WDOG_BIT]),
    .watchdog_delay_setting_i(watchdog_delay_setting_i),
    .comm_fault_o(wd_fault)
  );

  // ************************************
  // registered outputs
  // ************************************
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control_o <= '{state: SW_INHIBIT, stop_kind: STOP_NONE, ramp_mode: RAMP_FOLLOW,
                     default: '0};
      command_word_o <= `COMMAND_WORD_RESET;
      watchdog_echo_o <= 1'b0;
      comm_fault_o <= 1'b0;
      bus_virtual_input_1_o <= 1'b0;
      bus_virtual_input_2_o <= 1'b0;
      bus_virtual_input_3_o <= 1'b0;
      bus_virtual_input_4_o <= 1'b0;
    end else begin
      control_o.state <= next_state;
      control_o.stop_kind <= next_stop_kind;
      control_o.ramp_mode <= ramp_mode;
      control_o.run_request <= next_state == SW_RUNNING;
      control_o.jog1_active <= next_jog1;
      control_o.jog2_active <= next_jog2;
      control_o.fault_ack <= ack_rise;
      control_o.quick_stop_mode <= stat.quick_stop_mode;
      control_o.fieldbus_active <= fb_enabled;
      command_word_o <= command_word;
      watchdog_echo_o <= command_word[`CW_WDOG_BIT];
      comm_fault_o <= wd_fault;
      bus_virtual_input_1_o <= command_word[`CW_WDOG_BIT];
      bus_virtual_input_2_o <= command_word[12];
      bus_virtual_input_3_o <= command_word[13];
      bus_virtual_input_4_o <= command_word[14];
    end
  end
endmodule

// ---- drive_fieldbus_command_decoder_checker.sv ----
// port assertions for the fieldbus command word decoder
`include "cmd_decoder_params.svh"
module drive_fieldbus_command_decoder_checker #(
  parameter int WDOG_TICK = 10
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_write_i,
  input wire logic [15:0] fieldbus_command_word_i,
  input wire logic [2:0] control_place_select_i,
  input wire logic [15:0] watchdog_delay_setting_i,
  input wire cmd_decoder_pkg::drive_status_type status_i,
  input wire cmd_decoder_pkg::drive_control_type control_o,
  input wire logic [15:0] command_word_o,
  input wire logic watchdog_echo_o,
  input wire logic comm_fault_o,
  input wire logic bus_virtual_input_1_o,
  input wire logic bus_virtual_input_2_o,
  input wire logic bus_virtual_input_3_o,
  input wire logic bus_virtual_input_4_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import cmd_decoder_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] w;
  logic ok;
  logic idle_jog;
  ramp_mode_type exp_ramp;
  assign w = fieldbus_command_word_i;
  assign ok = cmd_write_i && w[10] && (control_place_select_i == `PLACE_FIELDBUS);
  assign idle_jog = !control_o.jog1_active && !control_o.jog2_active;
  assign exp_ramp = !w[4] ? RAMP_OUT_ZERO : !w[5] ? RAMP_FREEZE : !w[6] ? RAMP_IN_ZERO :
    RAMP_FOLLOW;
  // ************
  // assertions
  // ************
  a_word_copy: assert property (ok |-> ##2 command_word_o == ($past(w, 2) & 16'h7FFF))
    else $error("accepted word not copied");
  a_internal_zero: assert property (command_word_o[15] == 1'b0)
    else $error("bit 15 not zero");
  a_echo_bits: assert property (ok |-> ##2 {watchdog_echo_o, bus_virtual_input_1_o,
    bus_virtual_input_2_o, bus_virtual_input_3_o, bus_virtual_input_4_o} ==
    {$past(w[11], 2), $past(w[11], 2), $past(w[12], 2), $past(w[13], 2), $past(w[14], 2)})
    else $error("echo or virtual inputs wrong");
  // previous write must have landed, else command_word_o still lags
  a_on_rise: assert property (ok && w[2:0] == 3'h7 && !command_word_o[0] &&
    !$past(cmd_write_i) && control_o.state == SW_INHIBIT && !status_i.fault_active
    |-> ##2 control_o.state == SW_READY_RUN) else $error("on rise ignored");
  a_coast_stop: assert property (ok && !w[1] && control_o.state == SW_RUNNING |-> ##2
    (control_o.stop_kind == STOP_COAST || control_o.state == SW_INHIBIT))
    else $error("coast stop missing");
  a_ramp_mode: assert property (ok && w[9:8] == 2'h0 && idle_jog &&
    control_o.state == SW_RUNNING |-> ##2 control_o.ramp_mode == $past(exp_ramp, 2))
    else $error("ramp mode priority wrong");
  a_jog_gate: assert property (ok && w[6:4] != 3'h0 && idle_jog && !status_i.io_jog1 &&
    !status_i.io_jog2 |-> ##2 !control_o.jog1_active && !control_o.jog2_active)
    else $error("jog taken with ramp bits set");
  a_ack_pulse: assert property ($rose(control_o.fault_ack) |=> !control_o.fault_ack)
    else $error("fault ack longer than one cycle");
  a_place_gate: assert property ((control_place_select_i != `PLACE_FIELDBUS)[*3]
    |-> !control_o.fieldbus_active) else $error("bus control outside fieldbus place");
  a_wdog_off: assert property ((watchdog_delay_setting_i == 16'h0000)[*3]
    |-> !comm_fault_o) else $error("watchdog fault while disabled");
  c_running: cover property (control_o.state == SW_RUNNING);
  c_ack: cover property (control_o.fault_ack);
  c_comm_fault: cover property ($rose(comm_fault_o));
endmodule
bind drive_fieldbus_command_decoder drive_fieldbus_command_decoder_checker #(
  .WDOG_TICK(WDOG_TICK)) i_drive_fieldbus_command_decoder_checker (.ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i), .cmd_write_i(cmd_write_i), .fieldbus_command_word_i(fieldbus_command_word_i),
  .control_place_select_i(control_place_select_i), .status_i(status_i),
  .watchdog_delay_setting_i(watchdog_delay_setting_i), .control_o(control_o),
  .command_word_o(command_word_o), .watchdog_echo_o(watchdog_echo_o),
  .comm_fault_o(comm_fault_o), .bus_virtual_input_1_o(bus_virtual_input_1_o),
  .bus_virtual_input_2_o(bus_virtual_input_2_o), .bus_virtual_input_3_o(bus_virtual_input_3_o),
  .bus_virtual_input_4_o(bus_virtual_input_4_o));

// ---- fieldbus_master_model.sv ----
// fieldbus master model: command word writes and watchdog toggling
module fieldbus_master_model #(
  parameter int HALF = 5
) (
  input wire logic ref_clk_i,
  input wire logic wdog_toggle_i,
  output logic cmd_write_o,
  output logic [15:0] word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] held = 16'h0000;
  // ************
  // bus cycles
  // ************
  initial begin
    cmd_write_o = 1'b0;
    word_o = 16'hFFFF;
  end
  // idle bus shows the inverse so a stale word never looks valid
  task automatic pulse();
    word_o = held;
    cmd_write_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    cmd_write_o = 1'b0;
    word_o = ~held;
  endtask
  task automatic write(input logic [15:0] w);
    held = w;
    @(posedge ref_clk_i);
    #1;
    pulse();
  endtask
  // scaled square wave on the watchdog bit
  always begin
    @(posedge ref_clk_i);
    if (wdog_toggle_i) begin
      repeat (HALF - 1) @(posedge ref_clk_i);
      #1;
      held[11] = ~held[11];
      pulse();
    end
  end
endmodule

// ---- test_drive_fieldbus_command_decoder.sv ----
// self-checking bench for the fieldbus command word decoder
module test_drive_fieldbus_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import cmd_decoder_pkg::*;
  logic ref_clk_i;
  logic rstn_i;
  logic cmd_write;
  logic [15:0] word;
  logic [2:0] place;
  logic [15:0] wdog_delay;
  logic wdog_toggle;
  drive_status_type st;
  drive_control_type ctl;
  logic [15:0] cw_out;
  logic echo, comm_fault, vi1, vi2, vi3, vi4;
  int n_errors = 0;
  int checks_done = 0;
  int n_ack = 0;
  int cycles = 0;
  logic [15:0] ramp_w [6] = '{16'h047F, 16'h046F, 16'h040F, 16'h045F, 16'h041F, 16'h043F};
  ramp_mode_type ramp_e [6] = '{RAMP_FOLLOW, RAMP_OUT_ZERO, RAMP_OUT_ZERO, RAMP_FREEZE,
    RAMP_FREEZE, RAMP_IN_ZERO};
  logic [15:0] stop_w [4] = '{16'h047E, 16'h047D, 16'h047B, 16'h007F};
  stop_kind_type stop_e [4] = '{STOP_RAMP, STOP_COAST, STOP_QUICK, STOP_COAST};
  drive_state_type end_e [4] = '{SW_READY_ON, SW_INHIBIT, SW_INHIBIT, SW_INHIBIT};
  // {jog1, jog2, word}
  logic [17:0] jog_t [6] = '{18'h00517, 18'h20507, 18'h00407, 18'h10607, 18'h00407, 18'h20707};
  fieldbus_master_model #(.HALF(5)) i_fieldbus_master_model (.ref_clk_i(ref_clk_i),
    .wdog_toggle_i(wdog_toggle), .cmd_write_o(cmd_write), .word_o(word));
  drive_fieldbus_command_decoder #(.WDOG_TICK(10)) i_drive_fieldbus_command_decoder (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cmd_write_i(cmd_write),
    .fieldbus_command_word_i(word), .control_place_select_i(place),
    .watchdog_delay_setting_i(wdog_delay), .status_i(st), .control_o(ctl),
    .command_word_o(cw_out), .watchdog_echo_o(echo), .comm_fault_o(comm_fault),
    .bus_virtual_input_1_o(vi1), .bus_virtual_input_2_o(vi2),
    .bus_virtual_input_3_o(vi3), .bus_virtual_input_4_o(vi4));
  // ************
  // helpers
  // ************
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (ctl.fault_ack === 1'b1) n_ack++;
    if (cycles == 6000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // four edges cover the two-edge answer plus margin
  task automatic wr(input logic [15:0] w);
    i_fieldbus_master_model.write(w);
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic restart();
    wr(16'h0406);
    wr(16'h0407);
    st.at_zero_speed = 1'b0;
    wr(16'h047F);
    chk(16'(ctl.state), 16'(SW_RUNNING), "running");
  endtask
  // ************
  // tests
  // ************
  initial begin
    rstn_i = 1'b0;
    place = 3'h3;
    wdog_delay = 16'h0000;
    wdog_toggle = 1'b0;
    st = '0;
    st.at_zero_speed = 1'b1;
    st.quick_stop_mode = 2'h2;
    idle(5);
    rstn_i = 1'b1;
    chk(16'(ctl.state), 16'(SW_INHIBIT), "reset state");
    chk(cw_out, 16'h0000, "reset word");
    restart();
    chk(16'(ctl.run_request), 16'h0001, "run request");
    wr(16'h0477);
    chk(16'(ctl.stop_kind), 16'(STOP_RAMP), "stop request");
    wr(16'h047F);
    for (int i = 0; i < 6; i++) begin
      wr(ramp_w[i]);
      chk(16'(ctl.ramp_mode), 16'(ramp_e[i]), "ramp mode");
    end
    wr(16'hF47F);
    chk(cw_out, 16'h747F, "word copy");
    chk(16'({echo, vi1, vi2, vi3, vi4}), 16'h0007, "echo low");
    wr(16'h7C7F);
    chk(16'({echo, vi1, vi2, vi3, vi4}), 16'h001F, "echo high");
    $display("test words done");
    for (int i = 0; i < 4; i++) begin
      wr(stop_w[i]);
      chk(16'(ctl.stop_kind), 16'(stop_e[i]), "stop kind");
      if (i == 2) chk(16'(ctl.quick_stop_mode), 16'h0002, "quick mode");
      st.at_zero_speed = 1'b1;
      idle(8);
      if (i != 2) chk(16'(ctl.state), 16'(end_e[i]), "end state");
      restart();
    end
    $display("test stops done");
    place = 3'h2;
    wr(16'h047F);
    chk(16'(ctl.fieldbus_active), 16'h0000, "place refused");
    place = 3'h3;
    wr(16'h047F);
    chk(16'(ctl.fieldbus_active), 16'h0001, "place fieldbus");
    st.fault_active = 1'b1;
    st.fault_removed_voltage = 1'b1;
    idle(4);
    chk(16'(ctl.state), 16'(SW_FAULT), "fault state");
    // cause gone, drive stays latched until the ack edge
    st.fault_active = 1'b0;
    n_ack = 0;
    wr(16'h04FF);
    idle(12);
    chk(16'(n_ack), 16'h0001, "single ack");
    chk(16'(ctl.state), 16'(SW_INHIBIT), "ack state");
    st.fault_removed_voltage = 1'b0;
    $display("test fault done");
    st.at_zero_speed = 1'b1;
    st.aux_jog_enable = 1'b1;
    idle(4);
    for (int i = 0; i < 6; i++) begin
      wr(jog_t[i][15:0]);
      chk(16'({ctl.jog1_active, ctl.jog2_active}), 16'(jog_t[i][17:16]), "jog");
    end
    wr(16'h0407);
    st.io_jog_enable = 1'b1;
    st.io_jog1 = 1'b1;
    idle(4);
    chk(16'({ctl.jog1_active, ctl.jog2_active}), 16'h0002, "io jog");
    st.io_jog2 = 1'b1;
    idle(4);
    chk(16'({ctl.jog1_active, ctl.jog2_active}), 16'h0000, "both io jogs");
    st.io_jog_enable = 1'b0;
    st.io_jog1 = 1'b0;
    st.io_jog2 = 1'b0;
    st.at_zero_speed = 1'b0;
    idle(4);
    wr(16'h0507);
    chk(16'({ctl.jog1_active, ctl.jog2_active}), 16'h0000, "jog while moving");
    $display("test jog done");
    chk(16'(comm_fault), 16'h0000, "watchdog off");
    wdog_delay = 16'h0002;
    wdog_toggle = 1'b1;
    idle(80);
    chk(16'(comm_fault), 16'h0000, "watchdog fed");
    wdog_toggle = 1'b0;
    idle(60);
    chk(16'(comm_fault), 16'h0001, "watchdog starved");
    $display("test watchdog done");
    summarize();
  end
endmodule

// ---- wdog_monitor.sv ----
// fieldbus watchdog pulse monitor
`include "cmd_decoder_params.svh"
module wdog_monitor #(
  parameter int TICK_CYCLES = `WDOG_TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic wdog_bit_i,
  input wire logic [15:0] watchdog_delay_setting_i,
  output logic comm_fault_o
);
  // ************************************
  // tick divider, one pulse per ms
  // ************************************
  logic [31:0] tick_cnt;
  logic tick;
  logic wdog_last;
  logic [15:0] quiet_ms;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // ************************************
  // toggle watch
  // ************************************
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_last <= 1'b0;
      quiet_ms <= 16'h0;
      comm_fault_o <= 1'b0;
    end else begin
      wdog_last <= wdog_bit_i;
      if (watchdog_delay_setting_i == 16'h0) begin
        quiet_ms <= 16'h0;
        comm_fault_o <= 1'b0;
      end else if (wdog_bit_i != wdog_last) begin
        quiet_ms <= 16'h0;
      end else if (tick && quiet_ms != 16'hFFFF) begin
        quiet_ms <= quiet_ms + 16'h1;
      end
      // fault is sticky until delay goes to zero, or until a toggle comes while quiet_ms is below the delay
      if (watchdog_delay_setting_i != 16'h0 && quiet_ms >= watchdog_delay_setting_i) begin
        comm_fault_o <= 1'b1;
      end else if (wdog_bit_i != wdog_last) begin
        comm_fault_o <= 1'b0;
      end
    end
  end
endmodule
